// file: src/audio_pwm_pkg.sv
package audio_pwm_pkg;

    // output timing
    localparam int CLK_HZ = 40000000;
    localparam int SAMPLE_HZ = 32000;
    localparam int PERIOD_CYCLES = CLK_HZ / SAMPLE_HZ;
    localparam int CNT_W = 11;
    localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(PERIOD_CYCLES - 1);

    // register map, 4-bit nibble registers
    localparam int ADDR_W = 4;
    localparam int DATA_W = 4;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] XLOW_ADDR = 4'h8;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h9;
    localparam logic [ADDR_W-1:0] LOW_ADDR = 4'hA;
    localparam logic [ADDR_W-1:0] HIGH_ADDR = 4'hB;
    localparam logic [ADDR_W-1:0] MASK_ADDR = 4'hC;
    localparam logic [ADDR_W-1:0] OPTION_ADDR = 4'hD;

    // field positions
    localparam int REQ_FLAG_BIT = 2;
    localparam int OUT_EN_BIT = 0;
    localparam int GIRQ_EN_BIT = 1;
    localparam int OPT_TEN_BIT = 0;
    localparam int OPT_TWELVE_BIT = 1;
    localparam int OPT_DAC_BIT = 2;
    localparam int OPT_WAKE_BIT = 3;

    // reset values
    localparam logic [DATA_W-1:0] NIBBLE_RESET = 4'h0;
    localparam logic [DATA_W-1:0] MASK_RESET = 4'h0;
    localparam logic [DATA_W-1:0] OPTION_RESET = 4'h0;

    localparam int MAG_W = 11;

    typedef enum logic [1:0] {
        RES8 = 2'b00,
        RES10 = 2'b01,
        RES12 = 2'b10
    } res_mode_e;

    typedef enum logic [1:0] {
        PIN_ACTIVE = 2'b00,
        PIN_FLOAT = 2'b01,
        PIN_WAKE = 2'b10
    } pin_state_e;

endpackage : audio_pwm_pkg

// file: src/sample_assembler.sv
`timescale 1ns/10ps
module sample_assembler (
    input wire logic [3:0] high_nib,
    input wire logic [3:0] low_nib,
    input wire logic [3:0] xlow_nib,
    input wire audio_pwm_pkg::res_mode_e res_mode,
    output logic sign,
    output logic [audio_pwm_pkg::MAG_W-1:0] magnitude
);

    // top bit of the high nibble is always the sign
    assign sign = high_nib[3];

    always_comb begin
        unique case (res_mode)
            audio_pwm_pkg::RES8: begin
                magnitude = {4'h0, high_nib[2:0], low_nib};
            end
            audio_pwm_pkg::RES10: begin
                magnitude = {2'h0, high_nib[2:0], low_nib, xlow_nib[3:2]};
            end
            audio_pwm_pkg::RES12: begin
                magnitude = {high_nib[2:0], low_nib, xlow_nib};
            end
            default: begin
                magnitude = 11'h000;
            end
        endcase
    end

endmodule : sample_assembler

// file: src/pulse_engine.sv
`timescale 1ns/10ps
module pulse_engine (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic sign_in,
    input wire logic [audio_pwm_pkg::MAG_W-1:0] mag_in,
    output logic period_end,
    output logic pos_drive,
    output logic neg_drive,
    output logic held_sign,
    output logic [audio_pwm_pkg::MAG_W-1:0] held_mag
);

    localparam int GAP = audio_pwm_pkg::PERIOD_CYCLES;
    logic run_q;
    logic [audio_pwm_pkg::CNT_W-1:0] cnt_reg;
    logic load;
    logic active;

    assign period_end = run_q && (cnt_reg == audio_pwm_pkg::PERIOD_LAST);
    // first sample is taken at start so the opening period is not silent
    assign load = (run && !run_q) || period_end;
    assign active = run_q && (cnt_reg < held_mag);
    assign pos_drive = active && !held_sign;
    assign neg_drive = active && held_sign;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            run_q <= 1'b0;
        end else begin
            run_q <= run;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= '0;
        end else if (!run || !run_q || period_end) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 11'h001;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            held_sign <= 1'b0;
            held_mag <= '0;
        end else if (load) begin
            held_sign <= sign_in;
            held_mag <= mag_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    logic [11:0] gap_cnt;
    logic gap_seen;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            gap_cnt <= 12'h000;
            gap_seen <= 1'b0;
        end else if (period_end || !run) begin
            gap_cnt <= 12'h000;
            gap_seen <= period_end;
        end else begin
            gap_cnt <= gap_cnt + 12'h001;
        end
    end

    property p_period_len;
        period_end && gap_seen |-> gap_cnt == 12'(GAP - 1);
    endproperty
    a_period_len: assert property (p_period_len) else $error("period length wrong");

    property p_hold;
        !load |=> $stable(held_mag) && $stable(held_sign);
    endproperty
    a_hold: assert property (p_hold) else $error("sample changed mid period");

endmodule : pulse_engine

// file: src/signed_audio_pwm_dac_output.sv
`timescale 1ns/10ps
module signed_audio_pwm_dac_output (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [audio_pwm_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [audio_pwm_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [audio_pwm_pkg::DATA_W-1:0] reg_rdata,
    input wire logic halt_active,
    output logic irq,
    output logic speaker_pos_pin_o,
    output logic speaker_pos_pin_oe,
    output logic speaker_neg_pin_o,
    output logic speaker_neg_pin_oe,
    input wire logic speaker_neg_pin_i,
    output logic speaker_wake,
    output logic dac_active,
    output logic dac_sign,
    output logic [audio_pwm_pkg::MAG_W-1:0] dac_magnitude
);

    ////////////////////////////////////////////////////////////////////////
    // register state

    logic [3:0] sample_high_reg;
    logic [3:0] sample_low_reg;
    logic [3:0] sample_extra_low_reg;
    logic audio_out_enable_reg;
    logic global_irq_enable_reg;
    logic sample_request_flag_reg;
    logic [3:0] mask_reg;
    logic [3:0] option_reg;
    logic [3:0] rdata_reg;
    logic halt_q;

    logic wr_status;
    logic wr_ctrl;
    logic wr_mask;
    logic wr_option;
    logic halt_entry;
    logic ten_bit_option;
    logic twelve_bit_option;
    logic dac_mode_option;
    logic speaker_wake_option;
    audio_pwm_pkg::res_mode_e res_mode;

    assign wr_status = reg_wr && (reg_addr == audio_pwm_pkg::STATUS_ADDR);
    assign wr_ctrl = reg_wr && (reg_addr == audio_pwm_pkg::CTRL_ADDR);
    assign wr_mask = reg_wr && (reg_addr == audio_pwm_pkg::MASK_ADDR);
    assign wr_option = reg_wr && (reg_addr == audio_pwm_pkg::OPTION_ADDR);
    assign halt_entry = halt_active && !halt_q;

    assign ten_bit_option = option_reg[audio_pwm_pkg::OPT_TEN_BIT];
    assign twelve_bit_option = option_reg[audio_pwm_pkg::OPT_TWELVE_BIT];
    assign dac_mode_option = option_reg[audio_pwm_pkg::OPT_DAC_BIT];
    assign speaker_wake_option = option_reg[audio_pwm_pkg::OPT_WAKE_BIT];

    // twelve wins; ten only counts with twelve clear
    assign res_mode = twelve_bit_option ? audio_pwm_pkg::RES12 :
                      ten_bit_option ? audio_pwm_pkg::RES10 :
                      audio_pwm_pkg::RES8;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            halt_q <= 1'b0;
        end else begin
            halt_q <= halt_active;
        end
    end

    // write-only nibbles form the holding buffer; the engine copies them
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sample_high_reg <= audio_pwm_pkg::NIBBLE_RESET;
            sample_low_reg <= audio_pwm_pkg::NIBBLE_RESET;
            sample_extra_low_reg <= audio_pwm_pkg::NIBBLE_RESET;
        end else if (reg_wr) begin
            if (reg_addr == audio_pwm_pkg::HIGH_ADDR) begin
                sample_high_reg <= reg_wdata;
            end
            if (reg_addr == audio_pwm_pkg::LOW_ADDR) begin
                sample_low_reg <= reg_wdata;
            end
            if (reg_addr == audio_pwm_pkg::XLOW_ADDR) begin
                sample_extra_low_reg <= reg_wdata;
            end
        end
    end

    // sleep entry beats a same-cycle enable write
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            audio_out_enable_reg <= 1'b0;
            global_irq_enable_reg <= 1'b0;
        end else begin
            if (halt_entry) begin
                audio_out_enable_reg <= 1'b0;
            end else if (wr_ctrl) begin
                audio_out_enable_reg <= reg_wdata[audio_pwm_pkg::OUT_EN_BIT];
            end
            if (wr_ctrl) begin
                global_irq_enable_reg <= reg_wdata[audio_pwm_pkg::GIRQ_EN_BIT];
            end
        end
    end

    // options are frozen while output runs so the mode cannot shift mid-stream
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            option_reg <= audio_pwm_pkg::OPTION_RESET;
        end else if (wr_option && !audio_out_enable_reg) begin
            option_reg <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mask_reg <= audio_pwm_pkg::MASK_RESET;
        end else if (wr_mask) begin
            mask_reg <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sample path

    logic sample_sign;
    logic [audio_pwm_pkg::MAG_W-1:0] sample_mag;
    logic period_end;
    logic pos_drive;
    logic neg_drive;
    logic engine_run;

    sample_assembler u_assembler (
        .high_nib(sample_high_reg),
        .low_nib(sample_low_reg),
        .xlow_nib(sample_extra_low_reg),
        .res_mode(res_mode),
        .sign(sample_sign),
        .magnitude(sample_mag)
    );

    assign engine_run = audio_out_enable_reg && !halt_active;

    pulse_engine u_engine (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .run(engine_run),
        .sign_in(sample_sign),
        .mag_in(sample_mag),
        .period_end(period_end),
        .pos_drive(pos_drive),
        .neg_drive(neg_drive),
        .held_sign(dac_sign),
        .held_mag(dac_magnitude)
    );

    // dac takes the same buffered sample; the pulse pins stay quiet then
    assign dac_active = engine_run && dac_mode_option;

    ////////////////////////////////////////////////////////////////////////
    // sample request and interrupt

    // a period end in the clearing cycle still sets the flag
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sample_request_flag_reg <= 1'b0;
        end else if (period_end) begin
            sample_request_flag_reg <= 1'b1;
        end else if (wr_status && reg_wdata[audio_pwm_pkg::REQ_FLAG_BIT]) begin
            sample_request_flag_reg <= 1'b0;
        end
    end

    assign irq = sample_request_flag_reg && mask_reg[audio_pwm_pkg::REQ_FLAG_BIT]
                 && global_irq_enable_reg;

    ////////////////////////////////////////////////////////////////////////
    // pin control

    audio_pwm_pkg::pin_state_e pin_state_reg;
    audio_pwm_pkg::pin_state_e pin_state_next;
    logic pos_o_next;
    logic neg_o_next;
    logic neg_meta;
    logic neg_sync;
    logic wake_reg;

    always_comb begin
        if (!halt_active) begin
            pin_state_next = audio_pwm_pkg::PIN_ACTIVE;
        end else if (speaker_wake_option) begin
            pin_state_next = audio_pwm_pkg::PIN_WAKE;
        end else begin
            pin_state_next = audio_pwm_pkg::PIN_FLOAT;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pin_state_reg <= audio_pwm_pkg::PIN_ACTIVE;
        end else begin
            pin_state_reg <= pin_state_next;
        end
    end

    always_comb begin
        pos_o_next = 1'b0;
        neg_o_next = 1'b0;
        unique case (pin_state_next)
            audio_pwm_pkg::PIN_ACTIVE: begin
                if (audio_out_enable_reg && !dac_mode_option) begin
                    pos_o_next = pos_drive;
                    neg_o_next = neg_drive;
                end
            end
            audio_pwm_pkg::PIN_FLOAT: begin
                pos_o_next = 1'b0;
            end
            audio_pwm_pkg::PIN_WAKE: begin
                neg_o_next = 1'b0;
            end
            default: begin
                pos_o_next = 1'b0;
            end
        endcase
    end

    // disabled output falls through to both pins low
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            speaker_pos_pin_o <= 1'b0;
            speaker_neg_pin_o <= 1'b0;
            speaker_pos_pin_oe <= 1'b1;
            speaker_neg_pin_oe <= 1'b1;
        end else begin
            speaker_pos_pin_o <= pos_o_next;
            speaker_neg_pin_o <= neg_o_next;
            speaker_pos_pin_oe <= pin_state_next != audio_pwm_pkg::PIN_FLOAT;
            speaker_neg_pin_oe <= pin_state_next != audio_pwm_pkg::PIN_FLOAT;
        end
    end

    // level on the grounded negative pin is the wake cue; pad is asynchronous
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            neg_meta <= 1'b0;
            neg_sync <= 1'b0;
        end else begin
            neg_meta <= speaker_neg_pin_i;
            neg_sync <= neg_meta;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= (pin_state_reg == audio_pwm_pkg::PIN_WAKE) && neg_sync;
        end
    end

    assign speaker_wake = wake_reg;

    ////////////////////////////////////////////////////////////////////////
    // register read, answer in the following cycle

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 4'h0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                audio_pwm_pkg::STATUS_ADDR: begin
                    rdata_reg <= {1'b0, sample_request_flag_reg, 2'h0};
                end
                audio_pwm_pkg::CTRL_ADDR: begin
                    rdata_reg <= {2'h0, global_irq_enable_reg, audio_out_enable_reg};
                end
                audio_pwm_pkg::MASK_ADDR: begin
                    rdata_reg <= mask_reg;
                end
                audio_pwm_pkg::OPTION_ADDR: begin
                    rdata_reg <= option_reg;
                end
                default: begin
                    rdata_reg <= 4'h0;
                end
            endcase
        end else begin
            rdata_reg <= 4'h0;
        end
    end

    assign reg_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_halt_entry;
        halt_active && !halt_q;
    endsequence

    sequence s_pins_low;
        !speaker_pos_pin_o && !speaker_neg_pin_o;
    endsequence

    property p_flag_set;
        period_end |=> sample_request_flag_reg;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("request flag not set");

    property p_irq;
        period_end && mask_reg[audio_pwm_pkg::REQ_FLAG_BIT] && global_irq_enable_reg
            && !wr_ctrl && !wr_mask
            |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_flag_hold;
        sample_request_flag_reg && !wr_status |=> sample_request_flag_reg;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

    property p_disabled_low;
        !audio_out_enable_reg |=> s_pins_low;
    endproperty
    a_disabled_low: assert property (p_disabled_low) else $error("pins not low");

    property p_halt_clears;
        s_halt_entry |=> !audio_out_enable_reg;
    endproperty
    a_halt_clears: assert property (p_halt_clears) else $error("enable kept");

    property p_halt_float;
        halt_active && !speaker_wake_option |=> !speaker_pos_pin_oe && !speaker_neg_pin_oe;
    endproperty
    a_halt_float: assert property (p_halt_float) else $error("pins driven");

    property p_wake_ground;
        halt_active && speaker_wake_option
            |=> speaker_pos_pin_oe && speaker_neg_pin_oe ##0 s_pins_low;
    endproperty
    a_wake_ground: assert property (p_wake_ground) else $error("wake pins");

    property p_one_pin;
        !(speaker_pos_pin_o && speaker_neg_pin_o);
    endproperty
    a_one_pin: assert property (p_one_pin) else $error("both pins high");

    property p_ctrl_read;
        reg_rd && reg_addr == audio_pwm_pkg::CTRL_ADDR
            |=> reg_rdata[0] == $past(audio_out_enable_reg);
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("enable readback");

    property p_dac_quiet;
        dac_mode_option |=> s_pins_low;
    endproperty
    a_dac_quiet: assert property (p_dac_quiet) else $error("pulse in dac mode");

endmodule : signed_audio_pwm_dac_output

// file: dv/speaker_load.sv
`timescale 1ns/10ps
// loudspeaker across the two pins; counts the cycles each pin is driven high
module speaker_load (
    input wire logic ref_clk,
    input wire logic pos_pin,
    input wire logic pos_en,
    input wire logic neg_pin,
    input wire logic neg_en,
    input wire logic sound,
    output logic neg_pad,
    output logic [15:0] pos_high_cnt,
    output logic [15:0] neg_high_cnt
);
    logic last_pad = 1'b0;
    initial begin
        pos_high_cnt = 16'h0;
        neg_high_cnt = 16'h0;
    end
    // a released pin has no keeper: show a changing level so nothing relies on it
    assign neg_pad = neg_en ? (neg_pin | sound) : (sound | ~last_pad);
    always @(posedge ref_clk) begin
        last_pad <= neg_pad;
        if (pos_en && pos_pin) begin
            pos_high_cnt <= pos_high_cnt + 16'h1;
        end
        if (neg_en && neg_pin) begin
            neg_high_cnt <= neg_high_cnt + 16'h1;
        end
    end
endmodule : speaker_load

// file: dv/signed_audio_pwm_dac_output_tb.sv
`timescale 1ns/10ps
module signed_audio_pwm_dac_output_tb;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [audio_pwm_pkg::ADDR_W-1:0] reg_addr = 4'h0;
    logic [audio_pwm_pkg::DATA_W-1:0] reg_wdata = 4'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic halt_active = 1'b0;
    logic sound = 1'b0;
    logic [audio_pwm_pkg::DATA_W-1:0] reg_rdata;
    logic irq, pos_o, pos_oe, neg_o, neg_oe, neg_i, speaker_wake, dac_active, dac_sign;
    logic [audio_pwm_pkg::MAG_W-1:0] dac_magnitude;
    logic [15:0] pos_cnt, neg_cnt, p0, n0;
    int errors = 0;
    int check_count = 0;
    int cyc = 0;
    int c0 = 0;
    // option, high, low, extra-low nibbles of each mode case
    logic [15:0] mode_tab [6] = '{16'h103C, 16'h17FC, 16'h2815, 16'h27FF, 16'h3007, 16'h4920};
    logic [15:0] exp_pos [6] = '{16'd15, 16'd511, 16'd0, 16'd1250, 16'd7, 16'd0};
    logic [15:0] exp_neg [6] = '{16'd0, 16'd0, 16'd21, 16'd0, 16'd0, 16'd0};

    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    signed_audio_pwm_dac_output dut (
        .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_active(halt_active),
        .irq(irq), .speaker_pos_pin_o(pos_o), .speaker_pos_pin_oe(pos_oe),
        .speaker_neg_pin_o(neg_o), .speaker_neg_pin_oe(neg_oe), .speaker_neg_pin_i(neg_i),
        .speaker_wake(speaker_wake), .dac_active(dac_active), .dac_sign(dac_sign),
        .dac_magnitude(dac_magnitude)
    );
    speaker_load spk (
        .ref_clk(ref_clk), .pos_pin(pos_o), .pos_en(pos_oe), .neg_pin(neg_o), .neg_en(neg_oe),
        .sound(sound), .neg_pad(neg_i), .pos_high_cnt(pos_cnt), .neg_high_cnt(neg_cnt)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [15:0] pins();
        return {12'h0, pos_oe, pos_o, neg_oe, neg_o};
    endfunction : pins

    task automatic wr(input logic [3:0] a, input logic [3:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read compare: masked read data against the expected value
    task automatic rdc(input logic [3:0] a, input logic [3:0] m, input logic [3:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check_count++;
        if ((reg_rdata & m) !== exp) begin
            errors++;
            $display("Error at %0t ns: read %h expected %h", $time, reg_rdata & m, exp);
        end
    endtask : rdc

    // waits for the next rise of irq and marks the window start there
    task automatic sync();
        int n;
        n = 0;
        while (irq === 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (irq !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            errors++;
            final_report();
        end
        c0 = cyc;
        p0 = pos_cnt;
        n0 = neg_cnt;
    endtask : sync

    // one whole output period: clear the flag, wait for the next request
    task automatic win(input logic [15:0] ep, input logic [15:0] en);
        int c;
        logic [15:0] p, q;
        c = c0;
        p = p0;
        q = n0;
        wr(4'h0, 4'h4);
        sync();
        chk(16'(c0 - c), 16'(audio_pwm_pkg::PERIOD_CYCLES));
        chk(pos_cnt - p, ep);
        chk(neg_cnt - q, en);
    endtask : win

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(25 * 80000);
        errors++;
        final_report();
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        @(negedge ref_clk);
        chk(pins(), 16'hA);
        chk(16'(irq), 16'h0);
        rdc(4'h9, 4'hF, 4'h0);
        rdc(4'h0, 4'h4, 4'h0);
        rdc(4'hB, 4'hF, 4'h0);
        rdc(4'h5, 4'hF, 4'h0);
        rdc(audio_pwm_pkg::MASK_ADDR, 4'hF, 4'h0);
        rdc(audio_pwm_pkg::OPTION_ADDR, 4'hF, 4'h0);
        $display("test reset_values done");

        wr(4'hB, 4'h1);
        wr(4'hA, 4'h4);
        wr(audio_pwm_pkg::MASK_ADDR, 4'h0);
        wr(4'h9, 4'h3);
        repeat (1300) @(negedge ref_clk);
        chk(16'(irq), 16'h0);
        rdc(4'h0, 4'h4, 4'h4);
        rdc(4'h9, 4'h3, 4'h3);
        wr(audio_pwm_pkg::OPTION_ADDR, 4'h1);
        rdc(audio_pwm_pkg::OPTION_ADDR, 4'hF, 4'h0);
        wr(audio_pwm_pkg::MASK_ADDR, 4'h4);
        @(negedge ref_clk);
        chk(16'(irq), 16'h1);
        wr(4'h0, 4'h4);
        rdc(4'h0, 4'h4, 4'h0);
        sync();
        win(16'd20, 16'd0);
        wr(4'hB, 4'h8);
        wr(4'hA, 4'h5);
        win(16'd20, 16'd0);
        win(16'd0, 16'd5);
        win(16'd0, 16'd5);
        $display("test pwm_8bit done");

        for (int i = 0; i < 6; i++) begin
            wr(4'h9, 4'h2);
            wr(4'h0, 4'h4);
            wr(audio_pwm_pkg::OPTION_ADDR, mode_tab[i][15:12]);
            wr(4'h8, mode_tab[i][3:0]);
            wr(4'hA, mode_tab[i][7:4]);
            wr(4'hB, mode_tab[i][11:8]);
            repeat (2) @(negedge ref_clk);
            chk(pins(), 16'hA);
            wr(4'h9, 4'h3);
            sync();
            win(exp_pos[i], exp_neg[i]);
        end
        chk(16'(dac_active), 16'h1);
        chk(16'(dac_sign), 16'h1);
        chk(16'(dac_magnitude), 16'h12);
        $display("test modes done");

        @(posedge ref_clk);
        halt_active <= 1'b1;
        repeat (2) @(negedge ref_clk);
        chk(pins() & 16'hA, 16'h0);
        rdc(4'h9, 4'h1, 4'h0);
        @(posedge ref_clk);
        halt_active <= 1'b0;
        repeat (2) @(negedge ref_clk);
        chk(pins(), 16'hA);
        $display("test sleep done");

        wr(4'h9, 4'h2);
        wr(4'h0, 4'h4);
        wr(audio_pwm_pkg::OPTION_ADDR, 4'h8);
        wr(4'hA, 4'h2);
        wr(4'hB, 4'h0);
        wr(4'h9, 4'h3);
        sync();
        win(16'd2, 16'd0);
        @(posedge ref_clk);
        halt_active <= 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(pins(), 16'hA);
        @(posedge ref_clk);
        sound <= 1'b1;
        repeat (6) @(negedge ref_clk);
        chk(16'(speaker_wake), 16'h1);
        $display("test speaker_wake done");
        final_report();
    end
endmodule : signed_audio_pwm_dac_output_tb
